/* design/rx_clock_pkg.sv */
// Notes on behaviour
// - reset pin low: low power, all state cleared
// - eight inputs into 8:2 mux, select at 04h
// - switch enabled and unlock: output external clock
// - measure external/master ratio, report at 18h
// - normally output the recovered master clock
// - 256x default, 128x when ratio bit set
// - disable bit at 04h floats master clock pin
package rx_clock_pkg;

	// =====================================================
	// register map
	localparam logic [7:0] CONTROL_ONE_ADDR        = 8'h01;
	localparam logic [7:0] CONTROL_FOUR_ADDR       = 8'h04;
	localparam logic [7:0] CLOCK_RATIO_STATUS_ADDR = 8'h18;

	localparam logic [7:0] CONTROL_ONE_RESET  = 8'h00;
	localparam logic [7:0] CONTROL_FOUR_RESET = 8'h00;
	localparam logic [7:0] RATIO_RESET        = 8'h00;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;

	// =====================================================
	// field positions
	localparam int SWITCH_ENABLE_BIT  = 7;
	localparam int RATIO_SELECT_BIT   = 1;
	localparam int OUT_DISABLE_BIT    = 7;
	localparam int RX_SELECT_LSB      = 3;
	localparam int PASS_SELECT_LSB    = 0;
	localparam int SELECT_WIDTH       = 3;

	// =====================================================
	// ratio measurement: master clock periods per window
	localparam logic [7:0] RATIO_WINDOW     = 8'h40;
	localparam logic [8:0] RATIO_SATURATION = 9'h0FF;

	typedef struct packed {
		logic       we;
		logic       re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef enum logic {
		SRC_RECOVERED,
		SRC_EXTERNAL
	} clock_source_e;

endpackage : rx_clock_pkg

/* design/clock_ratio_meter.sv */
module clock_ratio_meter
	import rx_clock_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       clear,
	input  wire logic       ref_rise,
	input  wire logic       meas_rise,
	output logic [7:0]      ratio_reg
);

	// =====================================================
	// window counting
	// ratio = reference edges per 64 master periods, 2.6 fixed point
	logic [7:0] window_reg;
	logic [8:0] count_reg;
	logic       window_done;

	assign window_done = meas_rise && (window_reg == RATIO_WINDOW - 8'h01);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			window_reg <= 8'h00;
		end else if (clear || window_done) begin
			window_reg <= 8'h00;
		end else if (meas_rise) begin
			window_reg <= window_reg + 8'h01;
		end
	end

	// saturate so a slow master clock cannot wrap to a small ratio
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 9'h000;
		end else if (clear) begin
			count_reg <= 9'h000;
		end else if (window_done) begin
			// edge on the boundary opens the next window, none lost
			count_reg <= {8'h00, ref_rise};
		end else if (ref_rise && count_reg != RATIO_SATURATION) begin
			count_reg <= count_reg + 9'h001;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ratio_reg <= RATIO_RESET;
		end else if (clear) begin
			ratio_reg <= RATIO_RESET;
		end else if (window_done) begin
			ratio_reg <= count_reg[7:0];
		end
	end

endmodule : clock_ratio_meter

/* design/rx_clock_control.sv */
module rx_clock_control
	import rx_clock_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       chip_reset_n,
	input  wire reg_req_s   reg_req,
	output logic [7:0]      reg_rdata,
	output logic            reg_rvalid,
	input  wire logic [7:0] positive_receiver_inputs,
	output logic            rx_data_sel,
	output logic            pass_data_sel,
	input  wire logic       pll_clock,
	input  wire logic       pll_locked,
	input  wire logic       ext_system_clock_in,
	output logic            master_clock_out,
	output logic            master_clock_oe,
	output logic            low_power_mode
);

	// =====================================================
	// chip reset
	// held low it clears everything synchronously, on top of sys_rst
	logic chip_hold;
	assign chip_hold = !chip_reset_n;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			low_power_mode <= 1'b1;
		end else begin
			low_power_mode <= chip_hold;
		end
	end

	// =====================================================
	// registers
	logic [7:0] control_one_reg;
	logic [7:0] control_four_reg;
	logic [7:0] clock_ratio_status_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			control_one_reg <= CONTROL_ONE_RESET;
		end else if (chip_hold) begin
			control_one_reg <= CONTROL_ONE_RESET;
		end else if (reg_req.we && reg_req.addr == CONTROL_ONE_ADDR) begin
			control_one_reg <= reg_req.wdata;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			control_four_reg <= CONTROL_FOUR_RESET;
		end else if (chip_hold) begin
			control_four_reg <= CONTROL_FOUR_RESET;
		end else if (reg_req.we && reg_req.addr == CONTROL_FOUR_ADDR) begin
			control_four_reg <= reg_req.wdata;
		end
	end

	// ratio register is read only, writes are dropped
	logic [7:0] read_next;

	always_comb begin
		unique case (reg_req.addr)
			CONTROL_ONE_ADDR:        read_next = control_one_reg;
			CONTROL_FOUR_ADDR:       read_next = control_four_reg;
			CLOCK_RATIO_STATUS_ADDR: read_next = clock_ratio_status_reg;
			default:                 read_next = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata  <= UNMAPPED_READ;
			reg_rvalid <= 1'b0;
		end else if (chip_hold) begin
			reg_rdata  <= UNMAPPED_READ;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.re;
			if (reg_req.re) begin
				reg_rdata <= read_next;
			end
		end
	end

	// =====================================================
	// control fields
	logic                    switch_enable;
	logic                    ratio_select;
	logic                    out_disable;
	logic [SELECT_WIDTH-1:0] rx_select;
	logic [SELECT_WIDTH-1:0] pass_select;

	assign switch_enable = control_one_reg[SWITCH_ENABLE_BIT];
	assign ratio_select  = control_one_reg[RATIO_SELECT_BIT];
	assign out_disable   = control_four_reg[OUT_DISABLE_BIT];
	assign rx_select     = control_four_reg[RX_SELECT_LSB +: SELECT_WIDTH];
	assign pass_select   = control_four_reg[PASS_SELECT_LSB +: SELECT_WIDTH];

	// =====================================================
	// input multiplexer
	// two independent taps: one to the decoder, one passed through
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data_sel   <= 1'b0;
			pass_data_sel <= 1'b0;
		end else if (chip_hold) begin
			rx_data_sel   <= 1'b0;
			pass_data_sel <= 1'b0;
		end else begin
			rx_data_sel   <= positive_receiver_inputs[rx_select];
			pass_data_sel <= positive_receiver_inputs[pass_select];
		end
	end

	// =====================================================
	// edge detection of sampled clocks
	logic pll_prev_reg;
	logic ext_prev_reg;
	logic pll_rise;
	logic ext_rise;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pll_prev_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else if (chip_hold) begin
			pll_prev_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			pll_prev_reg <= pll_clock;
			ext_prev_reg <= ext_system_clock_in;
		end
	end

	assign pll_rise = pll_clock && !pll_prev_reg;
	assign ext_rise = ext_system_clock_in && !ext_prev_reg;

	// =====================================================
	// recovered clock rate
	// pll runs at 256x; halving it gives 128x without retuning the loop
	logic half_reg;
	logic recovered_clock;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			half_reg <= 1'b0;
		end else if (chip_hold) begin
			half_reg <= 1'b0;
		end else if (pll_rise) begin
			half_reg <= !half_reg;
		end
	end

	assign recovered_clock = ratio_select ? half_reg : pll_prev_reg;

	// =====================================================
	// source selection
	clock_source_e source_reg;
	clock_source_e source_next;

	always_comb begin
		source_next = source_reg;
		unique case (source_reg)
			SRC_RECOVERED: begin
				if (switch_enable && !pll_locked) begin
					source_next = SRC_EXTERNAL;
				end
			end
			SRC_EXTERNAL: begin
				if (pll_locked || !switch_enable) begin
					source_next = SRC_RECOVERED;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			source_reg <= SRC_RECOVERED;
		end else if (chip_hold) begin
			source_reg <= SRC_RECOVERED;
		end else begin
			source_reg <= source_next;
		end
	end

	// =====================================================
	// output pin
	// two cycles of latency on both paths keeps the switch glitch-aligned
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			master_clock_out <= 1'b0;
			master_clock_oe  <= 1'b0;
		end else if (chip_hold) begin
			master_clock_out <= 1'b0;
			master_clock_oe  <= 1'b0;
		end else begin
			master_clock_oe <= !out_disable;
			if (source_reg == SRC_EXTERNAL) begin
				master_clock_out <= ext_prev_reg;
			end else begin
				master_clock_out <= recovered_clock;
			end
		end
	end

	// =====================================================
	// ratio measurement
	// measured against the selected recovered clock, not the pin
	logic meas_rise;
	logic rec_prev_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rec_prev_reg <= 1'b0;
		end else if (chip_hold) begin
			rec_prev_reg <= 1'b0;
		end else begin
			rec_prev_reg <= recovered_clock;
		end
	end

	assign meas_rise = recovered_clock && !rec_prev_reg;

	clock_ratio_meter ratio_meter (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.clear     (chip_hold),
		.ref_rise  (ext_rise),
		.meas_rise (meas_rise),
		.ratio_reg (clock_ratio_status_reg)
	);

endmodule : rx_clock_control

/* tb/rx_clock_sva.sv */
module rx_clock_sva
	import rx_clock_pkg::*;
(
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       chip_reset_n,
	input wire reg_req_s   reg_req,
	input wire logic [7:0] positive_receiver_inputs,
	input wire logic       rx_data_sel,
	input wire logic       reg_rvalid,
	input wire logic       pll_clock,
	input wire logic       pll_locked,
	input wire logic       ext_system_clock_in,
	input wire logic       master_clock_out,
	input wire logic       master_clock_oe,
	input wire logic       low_power_mode
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       up;
	logic       sw;
	logic       r128;
	logic [2:0] sel;
	wire        wr  = reg_req.we && chip_reset_n;
	wire        run = up && master_clock_oe;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========
	// shadow of control bits; chip reset wipes it as it does the design
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst || !chip_reset_n) begin
			up   <= 1'b0;
			sw   <= 1'b0;
			r128 <= 1'b0;
			sel  <= 3'h0;
		end else begin
			up <= 1'b1;
			if (wr && reg_req.addr == CONTROL_ONE_ADDR) begin
				sw   <= reg_req.wdata[SWITCH_ENABLE_BIT];
				r128 <= reg_req.wdata[RATIO_SELECT_BIT];
			end
			if (wr && reg_req.addr == CONTROL_FOUR_ADDR) begin
				sel <= reg_req.wdata[RX_SELECT_LSB+:SELECT_WIDTH];
			end
		end
	end
	// ==========
	// properties
	property p_low_power; !chip_reset_n |=> low_power_mode; endproperty
	a_low_power: assert property (p_low_power) else $error("no low power");
	property p_clear; !chip_reset_n |=> !reg_rvalid && !rx_data_sel && !master_clock_oe; endproperty
	a_clear: assert property (p_clear) else $error("state kept in reset");
	property p_ratio_read; reg_req.re && chip_reset_n && reg_req.addr == CLOCK_RATIO_STATUS_ADDR |=> reg_rvalid; endproperty
	a_ratio_read: assert property (p_ratio_read) else $error("ratio read lost");
	property p_mux; up && sel == $past(sel) |-> rx_data_sel == $past(positive_receiver_inputs[sel]); endproperty
	a_mux: assert property (p_mux) else $error("wrong input");
	property p_float; wr && reg_req.addr == CONTROL_FOUR_ADDR && reg_req.wdata[OUT_DISABLE_BIT] |-> ##[1:2] !master_clock_oe; endproperty
	a_float: assert property (p_float) else $error("pin still driven");
	property p_ext; (run && sw && !pll_locked)[*4] |-> master_clock_out == $past(ext_system_clock_in, 2); endproperty
	a_ext: assert property (p_ext) else $error("ext clock absent");
	property p_rec; (run && pll_locked && !r128)[*4] |-> master_clock_out == $past(pll_clock, 2); endproperty
	a_rec: assert property (p_rec) else $error("recovered clock absent");
	property p_relock; sw && !pll_locked ##1 (run && sw && pll_locked && !r128)[*4] |-> master_clock_out == $past(pll_clock, 2); endproperty
	a_relock: assert property (p_relock) else $error("no return on relock");
	property p_half; (run && pll_locked && r128 && pll_clock != $past(pll_clock))[*6] |-> master_clock_out != $past(master_clock_out, 2); endproperty
	a_half: assert property (p_half) else $error("not half rate");
	c_ext: cover property (run && sw && !pll_locked);
	c_half: cover property (run && r128 && pll_locked);
	c_float: cover property (up && !master_clock_oe);
endmodule : rx_clock_sva

bind rx_clock_control rx_clock_sva u_sva (
	.clock                    (clock),
	.sys_rst                  (sys_rst),
	.chip_reset_n             (chip_reset_n),
	.reg_req                  (reg_req),
	.positive_receiver_inputs (positive_receiver_inputs),
	.rx_data_sel              (rx_data_sel),
	.reg_rvalid               (reg_rvalid),
	.pll_clock                (pll_clock),
	.pll_locked               (pll_locked),
	.ext_system_clock_in      (ext_system_clock_in),
	.master_clock_out         (master_clock_out),
	.master_clock_oe          (master_clock_oe),
	.low_power_mode           (low_power_mode)
);

/* tb/spdif_tx_model.sv */
module spdif_tx_model (
	input  wire logic       clock,
	output logic      [7:0] lines
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// one lfsr bit a line, so a wrong select shows within a few cycles
	initial lines = 8'h01;
	always @(posedge clock) lines <= #1 {lines[6:0], lines[7] ^ lines[5] ^ lines[4] ^ lines[3]};
endmodule : spdif_tx_model

/* tb/test_rx_input_select_and_master_clock_out.sv */
module test_rx_input_select_and_master_clock_out;
	timeunit 1ns;
	timeprecision 100ps;
	import rx_clock_pkg::*;
	logic       clock = 0, sys_rst = 1, chip_reset_n = 1;
	logic       pll_clock = 0, pll_locked = 1, ext = 1, slow = 0;
	reg_req_s   reg_req = '0;
	logic [7:0] lines, rdata;
	logic [3:0] s;
	logic       rvalid, rx_sel, pass_sel, mco, oe, lp;
	int         err_count = 0, samples_checked = 0, cyc = 0;
	spdif_tx_model u_tx (.clock(clock), .lines(lines));
	rx_clock_control u_dut (.clock(clock), .sys_rst(sys_rst), .chip_reset_n(chip_reset_n),
		.reg_req(reg_req), .reg_rdata(rdata), .reg_rvalid(rvalid), .positive_receiver_inputs(lines),
		.rx_data_sel(rx_sel), .pass_data_sel(pass_sel), .pll_clock(pll_clock), .pll_locked(pll_locked),
		.ext_system_clock_in(ext), .master_clock_out(mco), .master_clock_oe(oe), .low_power_mode(lp));
	initial forever #2 clock = ~clock;
	// ==========
	// ext in antiphase to pll, or half rate for the ratio
	always @(posedge clock) begin
		#1;
		cyc++;
		pll_clock <= ~pll_clock;
		ext <= slow ? cyc[1] : pll_clock;
		if (cyc > 6000) begin
			err_count++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_req <= '{1'b1, 1'b0, a, d};
		tick(1);
		reg_req <= '0;
		tick(1);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		tick(1);
		reg_req <= '0;
		chk(rvalid, 8'h01);
		chk(rdata, exp);
		tick(1);
	endtask : rd
	// pin is two edges behind its source, so it reads inverted here
	task follow(input logic use_ext);
		tick(4);
		repeat (4) begin
			tick(1);
			chk(mco, use_ext ? !ext : !pll_clock);
		end
	endtask : follow
	// ==========
	// main sequence
	initial begin
		tick(12);
		chk(lp, 8'h01);
		sys_rst <= 1'b0;
		tick(1);
		chk(lp, 8'h00);
		rd(CONTROL_ONE_ADDR, CONTROL_ONE_RESET);
		rd(CONTROL_FOUR_ADDR, CONTROL_FOUR_RESET);
		wr(CLOCK_RATIO_STATUS_ADDR, 8'hFF);
		rd(CLOCK_RATIO_STATUS_ADDR, RATIO_RESET);
		rd(8'h7F, UNMAPPED_READ);
		for (int k = 0; k < 8; k++) begin
			wr(CONTROL_FOUR_ADDR, {2'b00, k[2:0], 3'(7 - k)});
			repeat (4) begin
				tick(1);
				chk(rx_sel, lines[k]);
				chk(pass_sel, lines[7 - k]);
			end
		end
		follow(1'b0);
		wr(CONTROL_ONE_ADDR, 8'h80);
		pll_locked <= 1'b0;
		follow(1'b1);
		pll_locked <= 1'b1;
		follow(1'b0);
		wr(CONTROL_ONE_ADDR, 8'h02);
		tick(8);
		for (int i = 0; i < 4; i++) begin
			tick(1);
			s[i] = mco;
		end
		chk(s[2], !s[0]);
		chk(s[3], !s[1]);
		tick(600);
		rd(CLOCK_RATIO_STATUS_ADDR, 8'h80);
		wr(CONTROL_ONE_ADDR, 8'h00);
		tick(300);
		rd(CLOCK_RATIO_STATUS_ADDR, 8'h40);
		slow <= 1'b1;
		tick(300);
		rd(CLOCK_RATIO_STATUS_ADDR, 8'h20);
		slow <= 1'b0;
		wr(CONTROL_FOUR_ADDR, 8'h80);
		tick(1);
		chk(oe, 8'h00);
		wr(CONTROL_ONE_ADDR, 8'h82);
		chip_reset_n <= 1'b0;
		tick(2);
		chk(lp, 8'h01);
		chip_reset_n <= 1'b1;
		tick(2);
		rd(CONTROL_ONE_ADDR, 8'h00);
		rd(CLOCK_RATIO_STATUS_ADDR, 8'h00);
		chk(oe, 8'h01);
		print_verdict();
	end
endmodule : test_rx_input_select_and_master_clock_out
